// [src/pcm_pkg.sv]
package pcm_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL_TEN = 8'h00;
  localparam logic [7:0] ADR_PH_MON = 8'h01;
  localparam logic [7:0] ADR_STAT_TWO = 8'h02;
  localparam logic [7:0] ADR_STAT_THREE = 8'h03;
  localparam logic [7:0] ADR_SKEW = 8'h04;
  localparam logic [7:0] ADR_SYNTH_THREE = 8'h05;
  localparam logic [7:0] ADR_CTRL_ELEVEN = 8'h06;
  localparam logic [7:0] ADR_MAIN_CTRL_ONE = 8'h07;
  localparam logic [7:0] ADR_CTRL_FOUR = 8'h08;
  localparam logic [7:0] ADR_OFFSET0 = 8'h09;
  localparam logic [7:0] ADR_OFFSET1 = 8'h0A;
  localparam logic [7:0] ADR_OFFSET2 = 8'h0B;
  localparam logic [7:0] ADR_FREQ0 = 8'h0C;
  localparam logic [7:0] ADR_FREQ1 = 8'h0D;
  localparam logic [7:0] ADR_FREQ2 = 8'h0E;
  localparam logic [7:0] ADR_PHASE0 = 8'h0F;
  localparam logic [7:0] ADR_PHASE1 = 8'h10;
  // field positions
  localparam int BIT_BO_EN = 0;
  localparam int BIT_PM_EN = 7;
  localparam int BIT_MON_BO_EN = 6;
  localparam int BIT_RECALIBRATE_TRIGGER = 0;
  localparam int BIT_LOOP_SEL = 0;
  localparam int BIT_CMP_MODE = 0;
  localparam int BIT_FORCE_EN = 4;
  // reset values
  localparam logic [7:0] RST_PH_MON = 8'h00;
  localparam logic [7:0] RST_SKEW = 8'h00;
  localparam logic [3:0] RST_FORCE = 4'h0;
  // locking modes of a reference
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_LOW_RATE = 2'h1;
  localparam logic [1:0] MODE_DIVIDE = 2'h2;
  // ranges: offset 200 ns in 6 ps steps, freq 80 ppm at 0.0003068 ppm
  localparam int OFFSET_SPAN_PS = 200000;
  localparam int OFFSET_STEP_PS = 6;
  localparam logic signed [23:0] OFFSET_MAX = 24'(OFFSET_SPAN_PS / OFFSET_STEP_PS);
  localparam logic signed [23:0] FREQ_MAX = 24'h03FA94;
  // residual per build-out event, in offset steps of 6 ps
  localparam int RESID_PS = 5000;
  localparam logic signed [23:0] RESID_MAX = 24'(RESID_PS / OFFSET_STEP_PS);
  // phase monitor limit: base plus field times step, in ns
  localparam logic [15:0] PM_BASE_NS = 16'h03E8;
  localparam logic [15:0] PM_STEP_NS = 16'h00A7;
  // averaging shift, corner near 10 Hz at 250 MHz
  localparam int PH_AVG_SHIFT = 22;
  // offset ramp step per clock
  localparam logic signed [23:0] RAMP_STEP = 24'h000001;
  // timing
  localparam int CLK_NS = 4;
  localparam int PBO_HOLD_NS = 1000;
  localparam int RECALIBRATE_TRIGGER_HOLD_NS = 100;
  localparam int DIV_RST_NS = 40;
  localparam int PBO_HOLD_CYC = (PBO_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECALIBRATE_TRIGGER_HOLD_CYC = (RECALIBRATE_TRIGGER_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_RST_CYC = (DIV_RST_NS + CLK_NS - 1) / CLK_NS;
  // recalibration sequence
  typedef enum logic [5:0] {
    RC_IDLE = 6'h01,
    RC_HOLD = 6'h02,
    RC_RAMP_DN = 6'h04,
    RC_DIV_RST = 6'h08,
    RC_RAMP_UP = 6'h10,
    RC_EXIT = 6'h20
  } pcm_recalibrate_trigger_t;
endpackage

// [src/pcm_phase_ctrl.sv]
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - enable bit rise triggers one build-out event
// - phase read in degrees, offset in 6 ps steps
// - build-out residual bounded to five nanoseconds
// - fixed skew register added per build-out
// - offset shifts output phase, clamped span
// - offset applied gradually in feedback path
// - offset write immediately changes phase target
// - recalibrate bit starts realignment sequence
// - holdover, ramp down, divider reset, ramp up
// - offset written mid-recalibration becomes final target
// - frequency readback, loop select, integral value
// - frequency clamped to measurement range
// - phase readback averaged near 10 Hz corner
// - main phase is reference versus feedback
// - compare mode disables aux path, compares refs
// - force field picks aux reference
// - compare mode divides main copy when aux divided
// - direct aux lock leaves main copy undivided
// - main loop unaffected by compare mode
// - monitor sets alarm above programmed limit
module pcm_phase_ctrl
  import pcm_pkg::*;
(
  input wire logic clock_i, // 250 MHz master clock
  input wire logic rst_n_i, // async reset
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, next cycle
  input wire logic signed [15:0] main_phase_i, // main detector phase
  input wire logic signed [15:0] aux_phase_i, // aux detector phase
  input wire logic signed [23:0] main_freq_i, // main integral path
  input wire logic signed [23:0] aux_freq_i, // aux integral path
  input wire logic [15:0] pm_error_i, // monitor error, ns
  input wire logic main_state_chg_i, // main loop state change
  input wire logic signed [23:0] pbo_phase_i, // measured phase, 6 ps
  input wire logic [3:0] main_ref_sel_i, // main selected input
  input wire logic [3:0] aux_auto_sel_i, // aux automatic input
  input wire logic [1:0] main_ref_mode_i, // main lock mode
  input wire logic [1:0] aux_ref_mode_i, // aux lock mode
  output logic signed [23:0] fb_offset_o, // feedback offset
  output logic mini_holdover_o, // loop in mini holdover
  output logic divider_reset_o, // reset all dividers
  output logic [3:0] aux_ref_sel_o, // aux reference choice
  output logic [3:0] cmp_ref_sel_o, // reference copied to aux
  output logic aux_path_off_o, // aux path disabled
  output logic [1:0] copy_mode_o // copy divide mode
);

  // register state
  logic bo_en_q;
  logic bo_en_prev_q;
  logic [7:0] ph_mon_q;
  logic state_flag_q;
  logic alarm_flag_q;
  logic alarm_prev_q;
  logic signed [7:0] skew_q;
  logic loop_sel_q;
  logic cmp_mode_q;
  logic [4:0] force_q;
  logic signed [23:0] offset_q;
  logic [7:0] rdata_q;
  logic signed [37:0] ph_acc_q;
  logic signed [23:0] cur_off_q;
  logic signed [23:0] bo_acc_q;
  logic signed [23:0] fb_q;
  logic [15:0] pbo_cnt_q;
  logic pbo_busy_q;
  logic [15:0] rc_cnt_q;
  pcm_recalibrate_trigger_t rc_q;
  pcm_recalibrate_trigger_t rc_d;
  logic hold_q;
  logic div_rst_q;
  logic [3:0] aux_sel_q;
  logic [3:0] cmp_sel_q;
  logic aux_off_q;
  logic [1:0] copy_q;

  // address decode
  logic wr_ctrl;
  logic wr_pm;
  logic wr_st2;
  logic wr_st3;
  logic wr_skew;
  logic wr_synth;
  logic wr_sel;
  logic wr_cmp;
  logic wr_force;
  logic wr_off0;
  logic wr_off1;
  logic wr_off2;
  assign wr_ctrl = wr_i && addr_i == ADR_CTRL_TEN;
  assign wr_pm = wr_i && addr_i == ADR_PH_MON;
  assign wr_st2 = wr_i && addr_i == ADR_STAT_TWO;
  assign wr_st3 = wr_i && addr_i == ADR_STAT_THREE;
  assign wr_skew = wr_i && addr_i == ADR_SKEW;
  assign wr_synth = wr_i && addr_i == ADR_SYNTH_THREE;
  assign wr_sel = wr_i && addr_i == ADR_CTRL_ELEVEN;
  assign wr_cmp = wr_i && addr_i == ADR_MAIN_CTRL_ONE;
  assign wr_force = wr_i && addr_i == ADR_CTRL_FOUR;
  assign wr_off0 = wr_i && addr_i == ADR_OFFSET0;
  assign wr_off1 = wr_i && addr_i == ADR_OFFSET1;
  assign wr_off2 = wr_i && addr_i == ADR_OFFSET2;

  // control bits
  logic pm_en;
  logic mon_bo_en;
  logic all_bo_off;
  assign pm_en = ph_mon_q[BIT_PM_EN];
  assign mon_bo_en = ph_mon_q[BIT_MON_BO_EN];
  assign all_bo_off = !bo_en_q && !mon_bo_en;

  // phase monitor threshold compare
  logic [15:0] pm_limit;
  logic pm_over;
  assign pm_limit = PM_BASE_NS + PM_STEP_NS * {12'h000, ph_mon_q[3:0]};
  assign pm_over = pm_en && pm_error_i > pm_limit;

  // offset write assembly with span clamp
  // each byte takes effect alone, so the ramp may chase a half-written value
  logic signed [23:0] off_raw;
  logic signed [23:0] off_new;
  assign off_raw = wr_off0 ? {offset_q[23:8], wdata_i} :
                   wr_off1 ? {offset_q[23:16], wdata_i, offset_q[7:0]} :
                   {wdata_i, offset_q[15:0]};
  assign off_new = off_raw > OFFSET_MAX ? OFFSET_MAX :
                   off_raw < -OFFSET_MAX ? -OFFSET_MAX : off_raw;

  // build-out start: enable rise or automatic trigger
  // a further manual event needs the enable to fall and rise again
  logic bo_rise;
  logic auto_trig;
  logic pbo_start;
  logic pbo_done;
  assign bo_rise = bo_en_q && !bo_en_prev_q;
  assign auto_trig = mon_bo_en && pm_over && !alarm_prev_q;
  assign pbo_start = (bo_rise || auto_trig) && !pbo_busy_q;
  assign pbo_done = pbo_busy_q && pbo_cnt_q == 16'(PBO_HOLD_CYC - 1);

  // measured phase absorbed, residual bounded, fixed skew added
  logic signed [23:0] resid;
  logic signed [23:0] skew_ext;
  logic signed [23:0] bo_step;
  assign resid = pbo_phase_i > RESID_MAX ? RESID_MAX :
                 pbo_phase_i < -RESID_MAX ? -RESID_MAX : pbo_phase_i;
  assign skew_ext = {{16{skew_q[7]}}, skew_q};
  assign bo_step = pbo_phase_i - resid + skew_ext;

  // software control registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bo_en_q <= 1'b0;
      ph_mon_q <= RST_PH_MON;
      skew_q <= RST_SKEW;
      loop_sel_q <= 1'b0;
      cmp_mode_q <= 1'b0;
      force_q <= {1'b0, RST_FORCE};
    end else begin
      if (wr_ctrl) bo_en_q <= wdata_i[BIT_BO_EN];
      if (wr_pm) ph_mon_q <= wdata_i;
      if (wr_skew) skew_q <= wdata_i;
      if (wr_sel) loop_sel_q <= wdata_i[BIT_LOOP_SEL];
      if (wr_cmp) cmp_mode_q <= wdata_i[BIT_CMP_MODE];
      if (wr_force) force_q <= wdata_i[4:0];
    end
  end

  // offset target updates at once on a write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset_q <= 24'h000000;
    end else if (wr_off0 || wr_off1 || wr_off2) begin
      offset_q <= off_new;
    end
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_flag_q <= 1'b0;
      alarm_flag_q <= 1'b0;
      alarm_prev_q <= 1'b0;
    end else begin
      state_flag_q <= (state_flag_q && !(wr_st2 && wdata_i[0])) || main_state_chg_i;
      alarm_flag_q <= (alarm_flag_q && !(wr_st3 && wdata_i[0])) || pm_over;
      alarm_prev_q <= pm_over;
    end
  end

  // build-out event: holdover window then phase absorbed
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bo_en_prev_q <= 1'b0;
      pbo_busy_q <= 1'b0;
      pbo_cnt_q <= 16'h0000;
      bo_acc_q <= 24'h000000;
    end else begin
      bo_en_prev_q <= bo_en_q;
      if (pbo_start) begin
        pbo_busy_q <= 1'b1;
        pbo_cnt_q <= 16'h0000;
      end else if (pbo_done) begin
        pbo_busy_q <= 1'b0;
      end else if (pbo_busy_q) begin
        pbo_cnt_q <= pbo_cnt_q + 16'h0001;
      end
      if (all_bo_off) bo_acc_q <= 24'h000000;
      else if (pbo_done) bo_acc_q <= bo_acc_q - bo_step;
    end
  end

  // recalibration sequence, one-hot
  // a request while the sequence runs is dropped, not queued
  logic rc_start;
  logic rc_cnt_end;
  logic signed [23:0] ramp_tgt;
  logic at_tgt;
  assign rc_start = wr_synth && wdata_i[BIT_RECALIBRATE_TRIGGER];
  assign ramp_tgt = rc_q == RC_RAMP_DN || rc_q == RC_DIV_RST ? 24'h000000 :
                    offset_q;
  assign at_tgt = cur_off_q == ramp_tgt;

  always_comb begin
    rc_d = rc_q;
    case (rc_q)
      RC_IDLE: if (rc_start) rc_d = RC_HOLD;
      RC_HOLD: if (rc_cnt_end) rc_d = RC_RAMP_DN;
      RC_RAMP_DN: if (at_tgt) rc_d = RC_DIV_RST;
      RC_DIV_RST: if (rc_cnt_end) rc_d = RC_RAMP_UP;
      RC_RAMP_UP: if (at_tgt) rc_d = RC_EXIT;
      RC_EXIT: rc_d = RC_IDLE;
      default: rc_d = RC_IDLE;
    endcase
  end
  assign rc_cnt_end = rc_q == RC_HOLD ? rc_cnt_q == 16'(RECALIBRATE_TRIGGER_HOLD_CYC - 1) :
                      rc_cnt_q == 16'(DIV_RST_CYC - 1);

  // holdover while a sequence step or a build-out window is open
  logic hold_d;
  assign hold_d = (rc_d != RC_IDLE && rc_d != RC_EXIT) || pbo_start ||
                  (pbo_busy_q && !pbo_done);

  // sequence state and its timed outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_q <= RC_IDLE;
      rc_cnt_q <= 16'h0000;
      hold_q <= 1'b0;
      div_rst_q <= 1'b0;
    end else begin
      rc_q <= rc_d;
      rc_cnt_q <= rc_d != rc_q ? 16'h0000 : rc_cnt_q + 16'h0001;
      hold_q <= hold_d;
      div_rst_q <= rc_d == RC_DIV_RST;
    end
  end

  // offset ramps toward its target at a fixed rate
  logic signed [24:0] gap;
  logic signed [23:0] cur_d;
  assign gap = 25'(ramp_tgt) - 25'(cur_off_q);
  assign cur_d = gap > 25'(RAMP_STEP) ? cur_off_q + RAMP_STEP :
                 gap < -25'(RAMP_STEP) ? cur_off_q - RAMP_STEP : ramp_tgt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_off_q <= 24'h000000;
      fb_q <= 24'h000000;
    end else begin
      cur_off_q <= cur_d;
      fb_q <= cur_off_q + bo_acc_q;
    end
  end

  // phase readback: selected loop, averaged
  logic signed [15:0] ph_sel;
  logic signed [37:0] ph_ext;
  logic signed [37:0] ph_leak;
  logic signed [37:0] ph_acc_d;
  logic signed [23:0] fr_sel;
  logic signed [23:0] fr_clip;
  assign ph_sel = loop_sel_q ? aux_phase_i : main_phase_i;
  // every term stays signed so the leak shifts in sign bits
  assign ph_ext = {{22{ph_sel[15]}}, ph_sel};
  assign ph_leak = ph_acc_q >>> PH_AVG_SHIFT;
  assign ph_acc_d = ph_acc_q + ph_ext - ph_leak;
  assign fr_sel = loop_sel_q ? aux_freq_i : main_freq_i;
  assign fr_clip = fr_sel > FREQ_MAX ? FREQ_MAX :
                   fr_sel < -FREQ_MAX ? -FREQ_MAX : fr_sel;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) ph_acc_q <= 38'h0;
    else ph_acc_q <= ph_acc_d;
  end

  logic signed [15:0] ph_avg;
  assign ph_avg = ph_acc_q[37:22];

  // compare mode routing for the aux detector
  // the copy of the main reference follows the aux divide choice
  logic aux_div;
  logic [1:0] copy_d;
  logic [3:0] aux_sel_d;
  assign aux_div = aux_ref_mode_i != MODE_DIRECT;
  assign copy_d = !aux_div ? MODE_DIRECT :
                  main_ref_mode_i == MODE_DIVIDE ? MODE_DIVIDE : MODE_LOW_RATE;
  assign aux_sel_d = force_q[BIT_FORCE_EN] ? force_q[3:0] : aux_auto_sel_i;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_sel_q <= 4'h0;
      cmp_sel_q <= 4'h0;
      aux_off_q <= 1'b0;
      copy_q <= MODE_DIRECT;
    end else begin
      aux_sel_q <= aux_sel_d;
      cmp_sel_q <= main_ref_sel_i;
      aux_off_q <= cmp_mode_q;
      copy_q <= cmp_mode_q ? copy_d : MODE_DIRECT;
    end
  end

  // read mux; phase in degree steps, offset in 6 ps steps
  logic [7:0] rd_mux;
  logic rc_busy;
  assign rc_busy = rc_q != RC_IDLE;
  always_comb begin
    if (addr_i == ADR_CTRL_TEN) rd_mux = {7'h00, bo_en_q};
    else if (addr_i == ADR_PH_MON) rd_mux = ph_mon_q;
    else if (addr_i == ADR_STAT_TWO) rd_mux = {7'h00, state_flag_q};
    else if (addr_i == ADR_STAT_THREE) rd_mux = {7'h00, alarm_flag_q};
    else if (addr_i == ADR_SKEW) rd_mux = skew_q;
    else if (addr_i == ADR_SYNTH_THREE) rd_mux = {7'h00, rc_busy};
    else if (addr_i == ADR_CTRL_ELEVEN) rd_mux = {7'h00, loop_sel_q};
    else if (addr_i == ADR_MAIN_CTRL_ONE) rd_mux = {7'h00, cmp_mode_q};
    else if (addr_i == ADR_CTRL_FOUR) rd_mux = {3'h0, force_q};
    else if (addr_i == ADR_OFFSET0) rd_mux = offset_q[7:0];
    else if (addr_i == ADR_OFFSET1) rd_mux = offset_q[15:8];
    else if (addr_i == ADR_OFFSET2) rd_mux = offset_q[23:16];
    else if (addr_i == ADR_FREQ0) rd_mux = fr_clip[7:0];
    else if (addr_i == ADR_FREQ1) rd_mux = fr_clip[15:8];
    else if (addr_i == ADR_FREQ2) rd_mux = fr_clip[23:16];
    else if (addr_i == ADR_PHASE0) rd_mux = ph_avg[7:0];
    else if (addr_i == ADR_PHASE1) rd_mux = ph_avg[15:8];
    else rd_mux = 8'h00;
  end

  // read data stands only in the cycle after the strobe
  // zero outside the answer cycle keeps stale data off the bus
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_q <= 8'h00;
    else rdata_q <= rd_i ? rd_mux : 8'h00;
  end

  // outputs
  assign rdata_o = rdata_q;
  assign fb_offset_o = fb_q;
  assign mini_holdover_o = hold_q;
  assign divider_reset_o = div_rst_q;
  assign aux_ref_sel_o = aux_sel_q;
  assign cmp_ref_sel_o = cmp_sel_q;
  assign aux_path_off_o = aux_off_q;
  assign copy_mode_o = copy_q;

endmodule
`default_nettype wire

// [dv/pcm_phase_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pcm_phase_ctrl_assertions
  import pcm_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [7:0] addr_i, // address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] rdata_o, // read data
  input wire logic [3:0] main_ref_sel_i, // main input
  input wire logic [1:0] main_ref_mode_i, // main mode
  input wire logic [1:0] aux_ref_mode_i, // aux mode
  input wire logic signed [23:0] fb_offset_o, // offset
  input wire logic mini_holdover_o, // holdover
  input wire logic divider_reset_o, // divider reset
  input wire logic [3:0] cmp_ref_sel_o, // copied input
  input wire logic aux_path_off_o, // aux off
  input wire logic [1:0] copy_mode_o // copy mode
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [7:0] div_cnt_q;
  wire logic cmp_bit = wdata_i[BIT_CMP_MODE];
  // length of the divider reset pulse
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      div_cnt_q <= 8'h00;
    else
      div_cnt_q <= divider_reset_o ? div_cnt_q + 8'h01 : 8'h00;
  end
  // recalibration asked for while idle
  sequence s_recalibrate_trigger_req;
    wr_i && addr_i == ADR_SYNTH_THREE && wdata_i[BIT_RECALIBRATE_TRIGGER] && !mini_holdover_o
      && !divider_reset_o;
  endsequence
  sequence s_held;
    mini_holdover_o [*8];
  endsequence
  // compare mode with a direct or a divided aux reference
  sequence s_aux_direct;
    (aux_path_off_o && aux_ref_mode_i == MODE_DIRECT) [*3];
  endsequence
  sequence s_aux_divided;
    (aux_path_off_o && aux_ref_mode_i != MODE_DIRECT && $stable(main_ref_mode_i)) [*3];
  endsequence
  a_idle_read_zero:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
  a_cmp_mode_walk:
    assert property (wr_i && addr_i == ADR_MAIN_CTRL_ONE |->
      ##2 aux_path_off_o == $past(cmp_bit, 2))
      else $error("aux path off wrong");
  a_recalibrate_trigger_holdover:
    assert property (s_recalibrate_trigger_req |-> ##2 s_held) else $error("no recalibration holdover");
  a_div_in_hold:
    assert property (divider_reset_o |-> mini_holdover_o) else $error("divider reset outside hold");
  a_div_at_zero:
    assert property (divider_reset_o |-> fb_offset_o == 24'h000000) else $error("offset not zero");
  a_div_length:
    assert property ($fell(divider_reset_o) |-> div_cnt_q == 8'(DIV_RST_CYC))
      else $error("divider reset length wrong");
  a_hold_ramp_step:
    assert property (mini_holdover_o && $past(mini_holdover_o) |->
      24'(fb_offset_o - $past(fb_offset_o)) inside {24'h000000, 24'h000001, 24'hFFFFFF})
      else $error("offset step too large");
  a_copy_direct:
    assert property (s_aux_direct |-> copy_mode_o == MODE_DIRECT) else $error("copy not direct");
  a_copy_divided:
    assert property (s_aux_divided |->
      copy_mode_o == (main_ref_mode_i == MODE_DIVIDE ? MODE_DIVIDE : MODE_LOW_RATE))
      else $error("copy divide mode wrong");
  a_cmp_ref_copy:
    assert property ((aux_path_off_o && $stable(main_ref_sel_i)) [*3] |->
      cmp_ref_sel_o == main_ref_sel_i) else $error("copied reference wrong");
endmodule
bind pcm_phase_ctrl pcm_phase_ctrl_assertions chk_u (
  .clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .main_ref_sel_i,
  .main_ref_mode_i, .aux_ref_mode_i, .fb_offset_o, .mini_holdover_o, .divider_reset_o,
  .cmp_ref_sel_o, .aux_path_off_o, .copy_mode_o
);
`default_nettype wire

// [dv/pcm_phase_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pcm_phase_ctrl_tb
  import pcm_pkg::*;
();
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic signed [15:0] main_phase_i = 16'h0000;
  logic signed [15:0] aux_phase_i = 16'h0000;
  logic signed [23:0] main_freq_i = 24'h000000;
  logic signed [23:0] aux_freq_i = 24'h000000;
  logic [15:0] pm_error_i = 16'h0000;
  logic main_state_chg_i = 1'b0;
  logic signed [23:0] pbo_phase_i = 24'h000000;
  logic [3:0] main_ref_sel_i = 4'h3;
  logic [3:0] aux_auto_sel_i = 4'h5;
  logic [1:0] main_ref_mode_i = 2'h0;
  logic [1:0] aux_ref_mode_i = 2'h0;
  logic [7:0] rdata_o;
  logic signed [23:0] fb_offset_o;
  logic mini_holdover_o;
  logic divider_reset_o;
  logic [3:0] aux_ref_sel_o;
  logic [3:0] cmp_ref_sel_o;
  logic aux_path_off_o;
  logic [1:0] copy_mode_o;
  int err_total = 0;
  int num_checks = 0;
  logic [1:0] modes [3] = '{MODE_DIRECT, MODE_LOW_RATE, MODE_DIVIDE};
  logic [1:0] exp_mode;
  pcm_phase_ctrl dut_u (
    .clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .main_phase_i,
    .aux_phase_i, .main_freq_i, .aux_freq_i, .pm_error_i, .main_state_chg_i, .pbo_phase_i,
    .main_ref_sel_i, .aux_auto_sel_i, .main_ref_mode_i, .aux_ref_mode_i, .fb_offset_o,
    .mini_holdover_o, .divider_reset_o, .aux_ref_sel_o, .cmp_ref_sel_o, .aux_path_off_o,
    .copy_mode_o
  );
  // 250 MHz clock
  always #2 clock_i = ~clock_i;
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compare a register byte
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // compare a pin value
  task automatic chk_pin(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // one read cycle, data taken in the cycle after
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk_reg($sformatf("reg %h", a), e, rdata_o);
    @(posedge clock_i);
  endtask
  task automatic wr_off(input logic [23:0] v);
    wr(ADR_OFFSET0, v[7:0]);
    wr(ADR_OFFSET1, v[15:8]);
    wr(ADR_OFFSET2, v[23:16]);
  endtask
  task automatic rd_freq(input logic [23:0] e);
    rdc(ADR_FREQ0, e[7:0]);
    rdc(ADR_FREQ1, e[15:8]);
    rdc(ADR_FREQ2, e[23:16]);
  endtask
  // bounded wait for holdover or divider reset level
  task automatic wait_sig(input bit div, input logic lvl);
    int n = 0;
    while (((div ? divider_reset_o : mini_holdover_o) !== lvl) && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 2000) begin
      err_total++;
      $display("Error wait expected %b seen timeout", lvl);
      test_done();
    end
    @(posedge clock_i);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc(ADR_PH_MON, RST_PH_MON);
    rdc(ADR_SKEW, RST_SKEW);
    rdc(ADR_CTRL_FOUR, {4'h0, RST_FORCE});
    rdc(8'h11, 8'h00);
    main_freq_i <= 24'h012345;
    aux_freq_i <= 24'hFEDCBA;
    rd_freq(24'h012345);
    wr(ADR_CTRL_ELEVEN, 8'h01);
    rd_freq(24'hFEDCBA);
    aux_freq_i <= 24'h200000;
    rd_freq(FREQ_MAX);
    wr(ADR_CTRL_ELEVEN, 8'h00);
    // monitor limit 3: exact limit is no alarm, one above is
    pm_error_i <= PM_BASE_NS + 16'h0003 * PM_STEP_NS;
    wr(ADR_PH_MON, 8'h83);
    rdc(ADR_PH_MON, 8'h83);
    rdc(ADR_STAT_THREE, 8'h00);
    pm_error_i <= PM_BASE_NS + 16'h0003 * PM_STEP_NS + 16'h0001;
    repeat (3) @(posedge clock_i);
    rdc(ADR_STAT_THREE, 8'h01);
    pm_error_i <= 16'h0000;
    wr(ADR_STAT_THREE, 8'h01);
    rdc(ADR_STAT_THREE, 8'h00);
    main_state_chg_i <= 1'b1;
    @(posedge clock_i);
    main_state_chg_i <= 1'b0;
    rdc(ADR_STAT_TWO, 8'h01);
    wr(ADR_STAT_TWO, 8'h01);
    rdc(ADR_STAT_TWO, 8'h00);
    // compare mode over all lock mode pairs
    wr(ADR_MAIN_CTRL_ONE, 8'h01);
    for (int a = 0; a < 3; a++) begin
      for (int m = 0; m < 3; m++) begin
        aux_ref_mode_i <= modes[a];
        main_ref_mode_i <= modes[m];
        repeat (4) @(posedge clock_i);
        exp_mode = (a == 0) ? MODE_DIRECT : (m == 2 ? MODE_DIVIDE : MODE_LOW_RATE);
        chk_pin("copy mode", 24'(exp_mode), 24'(copy_mode_o));
      end
    end
    chk_pin("aux off", 24'h000001, 24'(aux_path_off_o));
    chk_pin("copy ref", 24'h000003, 24'(cmp_ref_sel_o));
    wr(ADR_CTRL_FOUR, 8'h1A);
    repeat (3) @(posedge clock_i);
    chk_pin("aux ref", 24'h00000A, 24'(aux_ref_sel_o));
    wr(ADR_CTRL_FOUR, 8'h00);
    wr(ADR_MAIN_CTRL_ONE, 8'h00);
    repeat (3) @(posedge clock_i);
    chk_pin("aux ref", 24'h000005, 24'(aux_ref_sel_o));
    chk_pin("aux off", 24'h000000, 24'(aux_path_off_o));
    // offset, then recalibration with a write in mid-run
    wr_off(24'h000064);
    repeat (120) @(posedge clock_i);
    chk_pin("offset", 24'h000064, fb_offset_o);
    wr(ADR_SYNTH_THREE, 8'h01);
    rdc(ADR_SYNTH_THREE, 8'h01);
    wr(ADR_OFFSET0, 8'h3C);
    wait_sig(1'b1, 1'b1);
    chk_pin("offset", 24'h000000, fb_offset_o);
    wait_sig(1'b0, 1'b0);
    chk_pin("offset", 24'h00003C, fb_offset_o);
    // one build-out event takes the skew off the accumulated phase
    wr(ADR_SKEW, 8'h05);
    wr(ADR_CTRL_TEN, 8'h01);
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b0, 1'b0);
    repeat (4) @(posedge clock_i);
    chk_pin("offset", 24'h000037, fb_offset_o);
    wr(ADR_CTRL_TEN, 8'h00);
    // out of range offset is clamped
    wr_off(24'hFF63C0);
    repeat (33600) @(posedge clock_i);
    chk_pin("offset", -OFFSET_MAX, fb_offset_o);
    test_done();
  end
endmodule
`default_nettype wire
